// ===== design/key_window_watchdog_regs.vh
// register offsets, key codes, field positions and timing constants of the key window watchdog
`ifndef KEY_WINDOW_WATCHDOG_REGS_VH
`define KEY_WINDOW_WATCHDOG_REGS_VH

// register byte offsets
`define OFS_COMMAND_KEY 8'h00
`define OFS_TIMEOUT_CONFIG 8'h04
`define OFS_REFRESH_LIMIT 8'h10
`define OFS_COUNT_VALUE 8'h14

// key codes written to command_key
`define KEY_START 16'hCCCC
`define KEY_REFRESH 16'hAAAA
`define KEY_UNLOCK 16'h5555

// field positions
`define KEY_MSB 15
`define TIMEOUT_SELECT_MSB 2
`define GUARD_LIMIT_MSB 11

// reset values
`define RST_TIMEOUT_SELECT 3'h0
`define RST_GUARD_LIMIT 12'h000
`define RST_TICK_COUNT 12'h000

// timing: oscillator cycles per count, and shortest count length
`define OSC_PRESCALE 128
`define BASE_COUNT_LEN 13'h0020

`endif

// ===== design/level_sync.v
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module level_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// levels
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage_a;
	reg [WIDTH-1:0] stage_b;

	// first stage is read only by the second stage, to let metastability settle
	always @(posedge sys_clk) begin
		if (!nrst) begin
			stage_a <= {WIDTH{1'b0}};
			stage_b <= {WIDTH{1'b0}};
		end else begin
			stage_a <= async_in;
			stage_b <= stage_a;
		end
	end

	assign sync_out = stage_b;

endmodule

// ===== design/key_window_watchdog.v
// independent key window watchdog: key register, protected setup and 12-bit up counter
`timescale 1ns/1ps
`include "key_window_watchdog_regs.vh"

module key_window_watchdog #(
	parameter PRESCALE = `OSC_PRESCALE,
	parameter ADDR_WIDTH = 8
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// word register access
	input wire reg_sel,
	input wire reg_write,
	input wire [ADDR_WIDTH-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg reg_ack,
	// low-speed oscillator and its enable
	input wire low_speed_osc,
	output reg osc_force_on,
	// power and debug state
	input wire debug_halt,
	input wire debug_freeze,
	input wire stop_mode,
	input wire stop_freeze_option,
	// system reset request
	output reg wdg_reset_req
);

	localparam PRE_W = 8;
	// last prescaler state, cut on purpose to the prescaler width
	localparam integer PRE_LAST_I = PRESCALE - 1;
	localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_I[PRE_W-1:0];

	// synchronised asynchronous inputs
	wire [4:0] sync_lv;
	wire osc_s;
	wire dbg_halt_s;
	wire dbg_freeze_s;
	wire stop_s;
	wire stop_opt_s;

	// watchdog state
	reg osc_prev;
	reg started;
	reg unlocked;
	reg [PRE_W-1:0] prescale_cnt;
	reg [`GUARD_LIMIT_MSB:0] tick_count;
	reg [`TIMEOUT_SELECT_MSB:0] timeout_select;
	reg [`GUARD_LIMIT_MSB:0] guard_limit;

	// decoded strobes
	wire wr_cmd;
	wire wr_cfg;
	wire wr_win;
	wire [`KEY_MSB:0] key_in;
	wire is_start;
	wire is_refresh;
	wire is_unlock;
	wire osc_edge;
	wire frozen;
	wire count_en;
	wire step;
	wire [12:0] count_next;
	wire [12:0] over_len;
	wire window_bad;
	wire refresh_ok;
	wire refresh_bad;

	// overflow count length for a selector value
	function [12:0] count_len;
		input [`TIMEOUT_SELECT_MSB:0] sel;
		begin
			count_len = `BASE_COUNT_LEN << sel;
		end
	endfunction

	// register address match used by every decode
	function addr_hit;
		input [ADDR_WIDTH-1:0] addr;
		input [7:0] ofs;
		begin
			addr_hit = (addr == ofs[ADDR_WIDTH-1:0]);
		end
	endfunction

	// pins from outside this clock pass two flops first
	level_sync #(
		.WIDTH(5)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in({low_speed_osc, debug_halt, debug_freeze, stop_mode, stop_freeze_option}),
		.sync_out(sync_lv)
	);

	assign osc_s = sync_lv[4];
	assign dbg_halt_s = sync_lv[3];
	assign dbg_freeze_s = sync_lv[2];
	assign stop_s = sync_lv[1];
	assign stop_opt_s = sync_lv[0];

	// write decode: word writes only, no byte lanes exist
	assign wr_cmd = reg_sel && reg_write && addr_hit(reg_addr, `OFS_COMMAND_KEY);
	assign wr_cfg = reg_sel && reg_write && addr_hit(reg_addr, `OFS_TIMEOUT_CONFIG);
	assign wr_win = reg_sel && reg_write && addr_hit(reg_addr, `OFS_REFRESH_LIMIT);
	assign key_in = reg_wdata[`KEY_MSB:0];
	assign is_start = wr_cmd && (key_in == `KEY_START);
	assign is_refresh = wr_cmd && (key_in == `KEY_REFRESH);
	assign is_unlock = wr_cmd && (key_in == `KEY_UNLOCK);

	// oscillator rising edge becomes a one-cycle enable
	assign osc_edge = osc_s && !osc_prev;

	// debug hold and stop option freeze; sleep has no input at all
	assign frozen = (dbg_halt_s && dbg_freeze_s) || (stop_s && stop_opt_s);
	assign count_en = started && osc_edge && !frozen;
	assign step = count_en && (prescale_cnt == PRE_LAST);

	// 13-bit sum so the 4096 length is reachable on a 12-bit counter
	assign count_next = {1'b0, tick_count} + 13'h0001;
	assign over_len = count_len(timeout_select);

	// window check: zero window accepts any count
	assign window_bad = (guard_limit != `RST_GUARD_LIMIT) && (tick_count <= guard_limit);
	assign refresh_ok = started && is_refresh && !window_bad;
	assign refresh_bad = started && is_refresh && window_bad;

	// remember oscillator level for edge detection
	always @(posedge sys_clk) begin
		if (!nrst) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc_s;
		end
	end

	// run state: set by start key, cleared only by reset
	always @(posedge sys_clk) begin
		if (!nrst) begin
			started <= 1'b0;
			osc_force_on <= 1'b0;
		end else if (is_start) begin
			started <= 1'b1;
			osc_force_on <= 1'b1;
		end
	end

	// unlock follows the last key written to command_key
	always @(posedge sys_clk) begin
		if (!nrst) begin
			unlocked <= 1'b0;
		end else if (wr_cmd) begin
			unlocked <= is_unlock;
		end
	end

	// protected setup registers
	always @(posedge sys_clk) begin
		if (!nrst) begin
			timeout_select <= `RST_TIMEOUT_SELECT;
			guard_limit <= `RST_GUARD_LIMIT;
		end else begin
			if (wr_cfg && unlocked) begin
				timeout_select <= reg_wdata[`TIMEOUT_SELECT_MSB:0];
			end
			if (wr_win && unlocked) begin
				guard_limit <= reg_wdata[`GUARD_LIMIT_MSB:0];
			end
		end
	end

	// prescaler and counter; first start and good refresh restart from zero
	always @(posedge sys_clk) begin
		if (!nrst) begin
			prescale_cnt <= {PRE_W{1'b0}};
			tick_count <= `RST_TICK_COUNT;
		end else if ((is_start && !started) || refresh_ok) begin
			prescale_cnt <= {PRE_W{1'b0}};
			tick_count <= `RST_TICK_COUNT;
		end else if (count_en) begin
			if (step) begin
				prescale_cnt <= {PRE_W{1'b0}};
				tick_count <= count_next[`GUARD_LIMIT_MSB:0];
			end else begin
				prescale_cnt <= prescale_cnt + 8'h01;
			end
		end
	end

	// reset request is sticky until the system reset clears this block
	always @(posedge sys_clk) begin
		if (!nrst) begin
			wdg_reset_req <= 1'b0;
		end else if ((step && (count_next == over_len)) || refresh_bad) begin
			wdg_reset_req <= 1'b1;
		end
	end

	// read data registered one cycle after the access; key reads zero
	always @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
			reg_ack <= 1'b0;
		end else begin
			reg_ack <= reg_sel;
			reg_rdata <= 32'h00000000;
			if (reg_sel && !reg_write) begin
				if (addr_hit(reg_addr, `OFS_TIMEOUT_CONFIG)) begin
					reg_rdata <= {29'h00000000, timeout_select};
				end else if (addr_hit(reg_addr, `OFS_REFRESH_LIMIT)) begin
					reg_rdata <= {20'h00000, guard_limit};
				end else if (addr_hit(reg_addr, `OFS_COUNT_VALUE)) begin
					reg_rdata <= {20'h00000, tick_count};
				end
			end
		end
	end

endmodule

// ===== testbench/kww_properties.sv
// port-level checks for the key window watchdog
`timescale 1ns/1ps
`include "key_window_watchdog_regs.vh"
module kww_properties #(
	parameter ADDR_WIDTH = 8
) (
	// clock and reset
	input wire sys_clk,
	input wire nrst,
	// register access
	input wire reg_sel,
	input wire reg_write,
	input wire [ADDR_WIDTH-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_ack,
	// watchdog outputs
	input wire osc_force_on,
	input wire wdg_reset_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// write of a key to the command register
	sequence s_key(k);
		reg_sel && reg_write && reg_addr == `OFS_COMMAND_KEY && reg_wdata[15:0] == k;
	endsequence
	// read request only; the properties check the answer one cycle later
	sequence s_read;
		reg_sel && !reg_write;
	endsequence
	a_ack_every_access: assert property (reg_sel |=> reg_ack)
		else $error("access not acknowledged");
	a_ack_no_request: assert property (!reg_sel |=> !reg_ack)
		else $error("ack without access");
	a_key_reads_zero: assert property (s_read and reg_addr == `OFS_COMMAND_KEY
		|=> reg_rdata == 32'h0) else $error("key read not zero");
	a_upper_bits_zero: assert property (s_read |=> reg_rdata[31:12] == 20'h0)
		else $error("upper read bits set");
	a_start_forces_osc: assert property (s_key(`KEY_START) |=> osc_force_on)
		else $error("osc not forced on");
	a_osc_held_on: assert property (osc_force_on |=> osc_force_on)
		else $error("watchdog stopped");
	a_req_sticky: assert property ($rose(wdg_reset_req) |=> wdg_reset_req[*8])
		else $error("reset request dropped");
	a_req_needs_start: assert property (!osc_force_on |-> !wdg_reset_req)
		else $error("reset request while idle");
endmodule
bind key_window_watchdog kww_properties #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.sys_clk(sys_clk),
	.nrst(nrst), .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
	.osc_force_on(osc_force_on), .wdg_reset_req(wdg_reset_req));

// ===== testbench/tb.sv
// self-checking bench for the key window watchdog
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_compared++; \
	if ((a) !== (e)) begin err_count++; $display("FAIL %0t %s", $time, m); end end
module tb;
	reg sys_clk = 0, nrst = 0, reg_sel = 0, reg_write = 0, low_speed_osc = 0;
	reg debug_halt = 0, debug_freeze = 0, stop_mode = 0, stop_freeze_option = 0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0, rd, r2;
	reg [15:0] modes = 16'hC832;
	reg [3:0] md;
	wire [31:0] reg_rdata;
	wire reg_ack, osc_force_on, wdg_reset_req;
	integer err_count = 0, n_compared = 0, i, j;
	// small prescale keeps overflow near 2k cycles
	key_window_watchdog #(.PRESCALE(4)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.low_speed_osc(low_speed_osc), .osc_force_on(osc_force_on),
		.debug_halt(debug_halt), .debug_freeze(debug_freeze), .stop_mode(stop_mode),
		.stop_freeze_option(stop_freeze_option), .wdg_reset_req(wdg_reset_req));
	// clocks: oscillator is 8 system cycles, one tick per 32 cycles
	initial forever #2 sys_clk = ~sys_clk;
	initial forever begin
		repeat (4) @(negedge sys_clk);
		low_speed_osc = ~low_speed_osc;
	end
	// one strobe access, answer taken the cycle after
	task acc(input w, input [7:0] a, input [31:0] d);
		begin
			@(negedge sys_clk);
			reg_sel = 1;
			reg_write = w;
			reg_addr = a;
			reg_wdata = d;
			@(negedge sys_clk);
			reg_sel = 0;
			rd = reg_rdata;
			`CHK(reg_ack, 1'b1, "no ack")
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] e);
		begin
			acc(0, a, 32'h0);
			`CHK(rd, e, "read")
		end
	endtask
	// poll the count until it shows a value, bounded
	task poll(input [31:0] v);
		begin
			rd = 0;
			for (i = 0; i < 300 && rd !== v; i++)
				acc(0, 8'h14, 32'h0);
			`CHK(rd, v, "count")
		end
	endtask
	task waitreq(input integer n);
		begin
			for (i = 0; i < n && wdg_reset_req !== 1'b1; i++)
				@(negedge sys_clk);
			`CHK(wdg_reset_req, 1'b1, "no reset")
		end
	endtask
	task rst;
		begin
			nrst = 0;
			repeat (20) @(negedge sys_clk);
			nrst = 1;
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// watchdog sized well above the expected 5k cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		end_of_test;
	end
	initial begin
		rst;
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		rdchk(8'h10, 32'h0);
		rdchk(8'h14, 32'h0);
		rdchk(8'h08, 32'h0);
		acc(1, 8'h04, 32'h3);
		rdchk(8'h04, 32'h0);
		acc(1, 8'h00, 32'h5555);
		acc(1, 8'h04, 32'hFFFFFFF9);
		rdchk(8'h04, 32'h1);
		acc(1, 8'h00, 32'h1234);
		acc(1, 8'h04, 32'h2);
		rdchk(8'h04, 32'h1);
		acc(1, 8'h00, 32'h5555);
		acc(1, 8'h10, 32'hFFFFF123);
		rdchk(8'h10, 32'h123);
		acc(1, 8'h10, 32'h0);
		$display("setup test done");
		acc(1, 8'h00, 32'hCCCC);
		`CHK(osc_force_on, 1'b1, "osc")
		poll(32'h2);
		acc(1, 8'h00, 32'hAAAA);
		rdchk(8'h14, 32'h0);
		// selector 1 gives 64 ticks of 32 cycles
		repeat (1500) @(negedge sys_clk);
		acc(1, 8'h00, 32'hAAAA);
		repeat (1950) @(negedge sys_clk);
		`CHK(wdg_reset_req, 1'b0, "early reset")
		waitreq(150);
		rst;
		`CHK(osc_force_on, 1'b0, "osc after reset")
		$display("overflow test done");
		acc(1, 8'h00, 32'hCCCC);
		// each mode: refresh, settle synchronisers, look for movement
		for (j = 0; j < 4; j++) begin
			md = modes[15 - 4 * j -: 4];
			acc(1, 8'h00, 32'hAAAA);
			{debug_halt, debug_freeze, stop_mode, stop_freeze_option} = md;
			repeat (20) @(negedge sys_clk);
			acc(0, 8'h14, 32'h0);
			r2 = rd;
			repeat (200) @(negedge sys_clk);
			acc(0, 8'h14, 32'h0);
			`CHK(rd === r2, (md[3] & md[2]) | (md[1] & md[0]), "freeze")
			{debug_halt, debug_freeze, stop_mode, stop_freeze_option} = 4'h0;
		end
		$display("freeze test done");
		// running timeout change: refresh, unlock, zero count, write, read back
		acc(1, 8'h00, 32'hAAAA);
		acc(1, 8'h00, 32'h5555);
		rdchk(8'h14, 32'h0);
		r2 = rd;
		acc(0, 8'h14, 32'h0);
		`CHK(rd, r2, "double read")
		acc(1, 8'h04, 32'h0);
		rdchk(8'h04, 32'h0);
		$display("timeout change test done");
		acc(1, 8'h00, 32'hAAAA);
		poll(32'h1);
		acc(1, 8'h00, 32'hAAAA);
		acc(1, 8'h00, 32'h5555);
		rdchk(8'h14, 32'h0);
		acc(1, 8'h10, 32'h2);
		rdchk(8'h10, 32'h2);
		poll(32'h3);
		acc(1, 8'h00, 32'hAAAA);
		repeat (5) @(negedge sys_clk);
		`CHK(wdg_reset_req, 1'b0, "refresh above window")
		acc(1, 8'h00, 32'hAAAA);
		waitreq(10);
		$display("window test done");
		end_of_test;
	end
endmodule
